// ### core/tma_pkg.sv
package tma_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 40;
  // Fixed alignment-loss window, inside the allowed 1 to 5 ms span
  localparam int unsigned LOM_TIME_US     = 2000;
  localparam int unsigned LOM_TIME_CYCLES =
    (LOM_TIME_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Overhead byte fields (bit 1 arrives first, lands in bit 7)
  // ----------------------------------------------------------------
  localparam int unsigned   MA_BIT_OFFSET       = 8;
  localparam int unsigned   LABEL_MSB           = 5;
  localparam int unsigned   LABEL_LSB           = 3;
  localparam int unsigned   MF_MSB              = 2;
  localparam int unsigned   MF_LSB              = 1;
  localparam logic [2:0]    LABEL_EXPECTED      = 3'h3;
  localparam logic [2:0]    LABEL_ACCEPT_FRAMES = 3'h5;
  localparam logic [2:0]    MF_ALIGN_FRAMES     = 3'h4;
  localparam logic [1:0]    MF_LAST_CODE        = 2'h0;

  // ----------------------------------------------------------------
  // Per-TU sink population
  // ----------------------------------------------------------------
  localparam int unsigned N_VC2    = 20;
  localparam int unsigned N_VC12   = 60;
  localparam int unsigned N_VC11   = 60;
  localparam int unsigned N_TU     = N_VC2 + N_VC12 + N_VC11;
  localparam int unsigned TU_WORDS = (N_TU + 31) / 32;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] REG_TU_ACT0   = 8'h10;
  localparam int unsigned CTRL_ACTIVATE  = 0;
  localparam logic        CTRL_RESET     = 1'h0;
  localparam int unsigned ST_PLM_CAUSE   = 0;
  localparam int unsigned ST_LOM_CAUSE   = 1;
  localparam int unsigned ST_IN_MF       = 2;
  localparam int unsigned ST_LABEL_LSB   = 4;
  localparam int unsigned IRQ_PLM        = 0;
  localparam int unsigned IRQ_LOM        = 1;
  localparam int unsigned IRQ_ALIGN      = 2;
  localparam int unsigned IRQ_BITS       = 3;

  typedef enum logic {
    out_of_multiframe_state,
    in_multiframe_state
  } tma_align_t;

  // Next expected multiframe code
  function automatic logic [1:0] tma_next_code(input logic [1:0] c);
    return c + 2'h1;
  endfunction

  function automatic logic [2:0] tma_label_of(input logic [7:0] b);
    return b[LABEL_MSB:LABEL_LSB];
  endfunction

  function automatic logic [1:0] tma_code_of(input logic [7:0] b);
    return b[MF_MSB:MF_LSB];
  endfunction

endpackage

// ### core/tma_sync.sv
`timescale 1ns/10ps
module tma_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  // Two stages; the first one feeds only the second
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // tma_sync

// ### core/tma_sink_top.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module tma_sink_top
  import tma_pkg::*;
#(
  parameter int unsigned LOM_CYCLES = LOM_TIME_CYCLES,
  parameter int unsigned MA_OFFSET  = MA_BIT_OFFSET
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             path_clk,
  input  wire logic             path_data,
  input  wire logic             path_frame_start,
  input  wire logic             incoming_trail_fail,
  output logic                  tug2_clk,
  output logic                  tug2_data,
  output logic                  tug2_frame_start,
  output logic                  sub_layer_multiframe_start,
  output logic                  downstream_signal_fail,
  output logic      [N_TU-1:0]  tu_signal_fail,
  output logic                  label_mismatch_cause,
  output logic                  multiframe_loss_cause,
  output logic                  irq
);

  localparam logic [15:0] MA_FIRST = 16'(MA_OFFSET);
  localparam logic [15:0] MA_LAST  = 16'(MA_OFFSET + 7);

  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  logic [3:0] link_s;
  logic       clk_d;
  logic       link_rise;
  logic       data_s;
  logic       fs_s;
  logic       trail_s;

  tma_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .din      ({path_clk, path_data, path_frame_start,
                incoming_trail_fail}),
    .dout     (link_s)
  );

  assign data_s    = link_s[2];
  assign fs_s      = link_s[1];
  assign trail_s   = link_s[0];
  assign link_rise = link_s[3] & ~clk_d;

  // Edge finder runs off the second sync stage only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      clk_d <= 1'b0;
    end else begin
      clk_d <= link_s[3];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tug2_clk         <= 1'b0;
      tug2_data        <= 1'b0;
      tug2_frame_start <= 1'b0;
    end else begin
      tug2_clk         <= link_s[3];
      tug2_data        <= data_s;
      tug2_frame_start <= fs_s;
    end
  end

  // ----------------------------------------------------------------
  // Overhead byte capture
  // ----------------------------------------------------------------
  logic [15:0] bit_cnt;
  logic [15:0] cur_idx;
  logic [7:0]  ma_shift;
  logic [7:0]  ma_byte;
  logic        ma_done;

  assign cur_idx = fs_s ? 16'h0 : bit_cnt;

  // Bit position counter saturates so a lost frame start is harmless
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bit_cnt <= 16'h0;
    end else if (link_rise) begin
      if (fs_s) begin
        bit_cnt <= 16'h1;
      end else if (bit_cnt != 16'hffff) begin
        bit_cnt <= bit_cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ma_shift <= 8'h0;
      ma_byte  <= 8'h0;
      ma_done  <= 1'b0;
    end else begin
      ma_done <= 1'b0;
      if (link_rise && cur_idx >= MA_FIRST && cur_idx <= MA_LAST) begin
        ma_shift <= {ma_shift[6:0], data_s};
        if (cur_idx == MA_LAST) begin
          ma_byte <= {ma_shift[6:0], data_s};
          ma_done <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Label acceptance and mismatch
  // ----------------------------------------------------------------
  logic [2:0] label_cand;
  logic [2:0] label_run;
  logic [2:0] accepted_label;
  logic       label_mismatch_defect;

  // Accepted only after a persistent value; reset holds expected code
  always_ff @(posedge core_clk) begin
    if (reset) begin
      label_cand     <= LABEL_EXPECTED;
      label_run      <= 3'h0;
      accepted_label <= LABEL_EXPECTED;
    end else if (ma_done) begin
      if (tma_label_of(ma_byte) != label_cand) begin
        label_cand <= tma_label_of(ma_byte);
        label_run  <= 3'h1;
      end else if (label_run < LABEL_ACCEPT_FRAMES) begin
        label_run <= label_run + 3'h1;
        if (label_run + 3'h1 == LABEL_ACCEPT_FRAMES) begin
          accepted_label <= label_cand;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      label_mismatch_defect <= 1'b0;
    end else begin
      label_mismatch_defect <= (accepted_label != LABEL_EXPECTED);
    end
  end

  // ----------------------------------------------------------------
  // Multiframe alignment
  // ----------------------------------------------------------------
  tma_align_t align_state;
  logic [1:0] prev_code;
  logic [2:0] good_run;
  logic [2:0] next_good_run;
  logic       code_ok;
  logic       mfs_armed;

  assign code_ok = (tma_code_of(ma_byte) == tma_next_code(prev_code));
  assign next_good_run = (good_run == 3'h0 || code_ok) ?
                         good_run + 3'h1 : 3'h1;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      align_state <= out_of_multiframe_state;
      prev_code   <= 2'h0;
      good_run    <= 3'h0;
    end else if (ma_done) begin
      prev_code <= tma_code_of(ma_byte);
      case (align_state)
        out_of_multiframe_state: begin
          good_run <= next_good_run;
          if (next_good_run == MF_ALIGN_FRAMES) begin
            align_state <= in_multiframe_state;
          end
        end
        in_multiframe_state: begin
          if (!code_ok) begin
            align_state <= out_of_multiframe_state;
            good_run    <= 3'h1;
          end
        end
        default: begin
          align_state <= out_of_multiframe_state;
        end
      endcase
    end
  end

  // mark frame after last code as multiframe start
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mfs_armed                  <= 1'b0;
      sub_layer_multiframe_start <= 1'b0;
    end else begin
      sub_layer_multiframe_start <= 1'b0;
      if (ma_done) begin
        mfs_armed <= (tma_code_of(ma_byte) == MF_LAST_CODE);
      end else if (link_rise && fs_s) begin
        sub_layer_multiframe_start <= mfs_armed &&
                                      align_state == in_multiframe_state;
        mfs_armed <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Loss-of-multiframe timer
  // ----------------------------------------------------------------
  logic [31:0] oom_cnt;
  logic        multiframe_loss_defect;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      oom_cnt                <= 32'h0;
      multiframe_loss_defect <= 1'b0;
    end else if (align_state == in_multiframe_state) begin
      oom_cnt                <= 32'h0;
      multiframe_loss_defect <= 1'b0;
    end else if (oom_cnt >= 32'(LOM_CYCLES)) begin
      multiframe_loss_defect <= 1'b1;
    end else begin
      oom_cnt <= oom_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                function_activate;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [31:0]         tu_word [TU_WORDS];
  logic [N_TU-1:0]     tu_active;
  logic                wr_en;
  logic                setup;
  logic [31:0]         next_rdata;
  logic                next_err;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    for (int i = 0; i < int'(N_TU); i++) begin
      tu_active[i] = tu_word[i / 32][i % 32];
    end
  end

  // Control and per-TU activation words
  always_ff @(posedge core_clk) begin
    if (reset) begin
      function_activate <= CTRL_RESET;
      irq_mask          <= '0;
      for (int i = 0; i < int'(TU_WORDS); i++) begin
        tu_word[i] <= 32'h0;
      end
    end else if (wr_en) begin
      if (paddr == REG_CTRL) begin
        function_activate <= pwdata[CTRL_ACTIVATE];
      end
      if (paddr == REG_IRQ_MASK) begin
        irq_mask <= pwdata[IRQ_BITS-1:0];
      end
      for (int i = 0; i < int'(TU_WORDS); i++) begin
        if (paddr == REG_TU_ACT0 + 8'(4 * i)) begin
          tu_word[i] <= pwdata;
        end
      end
    end
  end

  // Read mux decoded in the setup phase; unmapped reads answer error
  always_comb begin
    next_rdata = 32'h0;
    next_err   = 1'b0;
    case (paddr)
      REG_CTRL: next_rdata[CTRL_ACTIVATE] = function_activate;
      REG_STATUS: begin
        next_rdata[ST_PLM_CAUSE] = label_mismatch_cause;
        next_rdata[ST_LOM_CAUSE] = multiframe_loss_cause;
        next_rdata[ST_IN_MF]     = function_activate &&
                                   align_state == in_multiframe_state;
        next_rdata[ST_LABEL_LSB +: 3] =
          function_activate ? accepted_label : 3'h0;
      end
      REG_IRQ_STAT: next_rdata[IRQ_BITS-1:0] = irq_status;
      REG_IRQ_MASK: next_rdata[IRQ_BITS-1:0] = irq_mask;
      default: begin
        next_err = 1'b1;
        for (int i = 0; i < int'(TU_WORDS); i++) begin
          if (paddr == REG_TU_ACT0 + 8'(4 * i)) begin
            next_rdata = tu_word[i];
            next_err   = 1'b0;
          end
        end
      end
    endcase
  end

  // One wait-free access phase per transfer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= (setup && !pwrite) ? next_rdata : 32'h0;
      pslverr <= setup && next_err;
    end
  end

  // ----------------------------------------------------------------
  // Consequent actions, causes and interrupt
  // ----------------------------------------------------------------
  logic                server_fail_action;
  logic                next_plm_cause;
  logic                next_lom_cause;
  logic                aligned_q;
  logic [IRQ_BITS-1:0] irq_events;

  // either defect feeds the downstream fail
  assign server_fail_action = label_mismatch_defect |
                              multiframe_loss_defect;
  // mismatch cause gated by trail fail
  assign next_plm_cause = function_activate && label_mismatch_defect &&
                          !trail_s;
  // loss cause also masked by mismatch
  assign next_lom_cause = function_activate && multiframe_loss_defect &&
                          !trail_s && !label_mismatch_defect;
  assign irq_events = {
    function_activate && !aligned_q &&
      align_state == in_multiframe_state,
    next_lom_cause && !multiframe_loss_cause,
    next_plm_cause && !label_mismatch_cause};

  // per-TU fail, no exclusion between sinks
  always_ff @(posedge core_clk) begin
    if (reset) begin
      downstream_signal_fail <= 1'b1;
      tu_signal_fail         <= '1;
      label_mismatch_cause   <= 1'b0;
      multiframe_loss_cause  <= 1'b0;
      aligned_q              <= 1'b0;
    end else begin
      downstream_signal_fail <= server_fail_action || !function_activate;
      tu_signal_fail <= ~tu_active |
        {N_TU{server_fail_action || !function_activate}};
      label_mismatch_cause   <= next_plm_cause;
      multiframe_loss_cause  <= next_lom_cause;
      aligned_q <= align_state == in_multiframe_state;
    end
  end

  // Sticky status; a new event outranks a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status &
        ~((wr_en && paddr == REG_IRQ_STAT) ?
          pwdata[IRQ_BITS-1:0] : '0)) | irq_events;
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_label_mismatch_set: assert property (
    (accepted_label != LABEL_EXPECTED) |=> label_mismatch_defect)
    else $error("label mismatch not raised");
  a_label_match_clear: assert property (
    (accepted_label == LABEL_EXPECTED) |=> !label_mismatch_defect)
    else $error("mismatch with expected label");
  a_im_error_drop: assert property (
    (ma_done && !code_ok && align_state == in_multiframe_state)
    |=> align_state == out_of_multiframe_state)
    else $error("alignment kept after error");
  // entry only after four good frames
  a_im_entry_run: assert property (
    $rose(align_state == in_multiframe_state) |->
    good_run == MF_ALIGN_FRAMES && $past(ma_done))
    else $error("aligned without four frames");
  // loss only from unaligned state after window
  a_lom_after_window: assert property (
    $rose(multiframe_loss_defect) |->
    $past(align_state == out_of_multiframe_state) &&
    $past(oom_cnt) >= 32'(LOM_CYCLES))
    else $error("loss declared early");
  a_lom_clear_im: assert property (
    (align_state == in_multiframe_state) |=> !multiframe_loss_defect)
    else $error("loss kept while aligned");
  a_ssf_on_defect: assert property (
    server_fail_action |=> downstream_signal_fail)
    else $error("downstream fail missing");
  a_inactive_silent: assert property (
    !function_activate |=> downstream_signal_fail &&
    !label_mismatch_cause && !multiframe_loss_cause)
    else $error("inactive function reports");
  // mismatch cause tied to its terms
  a_plm_cause_terms: assert property (
    ##1 label_mismatch_cause == $past(function_activate &&
    label_mismatch_defect && !trail_s))
    else $error("mismatch cause wrong");
  a_lom_cause_terms: assert property (
    multiframe_loss_cause |-> $past(multiframe_loss_defect) &&
    !$past(label_mismatch_defect) && !$past(trail_s))
    else $error("loss cause wrong");
  a_mfs_when_aligned: assert property (
    sub_layer_multiframe_start |-> $past(align_state ==
    in_multiframe_state) && $past(fs_s))
    else $error("multiframe start while unaligned");

  c_align_gained: cover property ($rose(align_state ==
                                        in_multiframe_state));
  c_lom_declared: cover property ($rose(multiframe_loss_defect));
  c_plm_cause:    cover property ($rose(label_mismatch_cause));
  c_mfs_pulse:    cover property (sub_layer_multiframe_start);

endmodule // tma_sink_top

// ### tb/tma_path_model.sv
`timescale 1ns/10ps
// --------------------
// Path feed model
// --------------------
module tma_path_model (
  input  wire logic core_clk,
  output logic      path_clk,
  output logic      path_data,
  output logic      path_frame_start
);
  // Pins idle at time zero
  initial begin
    path_clk = 1'b0;
    path_data = 1'b0;
    path_frame_start = 1'b0;
  end
  // 16-bit frame, overhead byte MSB first at bit 8; the link clock
  // stops between frames so no stray edge is seen as a bit
  task automatic frame(input logic [2:0] lab, input logic [1:0] code);
    logic [15:0] bits;
    bits = {8'h00, 2'b00, lab, code, 1'b0};
    for (int i = 0; i < 16; i++) begin
      path_data        <= bits[15-i];
      path_frame_start <= (i == 0);
      repeat (4) @(posedge core_clk);
      path_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      path_clk <= 1'b0;
    end
    // Data parks at the inverse so a stale bit never looks valid
    path_data        <= ~bits[0];
    path_frame_start <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // tma_path_model

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import tma_pkg::*;
();
  // --------------------
  // Bench
  // --------------------
  localparam int LOM   = 2000;
  localparam int LIMIT = 15000;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0, td, prdata;
  logic        incoming_trail_fail = 1'b0;
  logic        pready, pslverr, path_clk, path_data, path_frame_start;
  logic        tug2_clk, tug2_data, tug2_frame_start, irq;
  logic        sub_layer_multiframe_start, downstream_signal_fail;
  logic        label_mismatch_cause, multiframe_loss_cause;
  logic [N_TU-1:0] tu_fail;
  logic [32:0] exp_q[$];
  logic [8:0]  hist = 9'h0;
  logic [1:0]  mf_code = 2'h1;
  logic        fwd_on = 1'b0;
  int          n_mismatch = 0, checks = 0, cyc_n = 0, mfs_n = 0, m0;
  int          seed = 32'h4888c6ce;

  always #20 core_clk = ~core_clk;

  tma_path_model tma_path_model_i (.core_clk(core_clk),
    .path_clk(path_clk), .path_data(path_data),
    .path_frame_start(path_frame_start));
  // Short loss window keeps the run brief
  tma_sink_top #(.LOM_CYCLES(LOM)) tma_sink_top_i (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .path_clk(path_clk),
    .path_data(path_data), .path_frame_start(path_frame_start),
    .incoming_trail_fail(incoming_trail_fail), .tug2_clk(tug2_clk),
    .tug2_data(tug2_data), .tug2_frame_start(tug2_frame_start),
    .sub_layer_multiframe_start(sub_layer_multiframe_start),
    .downstream_signal_fail(downstream_signal_fail),
    .tu_signal_fail(tu_fail),
    .label_mismatch_cause(label_mismatch_cause),
    .multiframe_loss_cause(multiframe_loss_cause), .irq(irq));

  task automatic cmp_val(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_lvl(input logic got, input logic exp);
    cmp_val({32'h0, got}, {32'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Read expectation is queued before the request goes out
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic frames(input int n, input logic [2:0] lab);
    repeat (n) begin
      tma_path_model_i.frame(lab, mf_code);
      mf_code = mf_code + 2'h1;
    end
    cyc(8);
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watcher: read words, forwarded pins, pulse count, hang limit
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp_val({pslverr, prdata}, exp_q.pop_front());
    if (fwd_on)
      cmp_val({30'h0, tug2_clk, tug2_data, tug2_frame_start},
              {30'h0, hist[8:6]});
    hist <= {hist[5:0], path_clk, path_data, path_frame_start};
    if (sub_layer_multiframe_start === 1'b1) mfs_n++;
    cyc_n++;
    if (cyc_n == LIMIT) begin
      n_mismatch++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    cyc(3);
    reset <= 1'b0;
    cyc(2);
    fwd_on <= 1'b1;
    cmp_lvl(downstream_signal_fail, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0, 33'h0);
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    td = $random(seed);
    apb(1'b1, REG_TU_ACT0, td, 33'h0);
    apb(1'b0, REG_TU_ACT0, 32'h0, {1'b0, td});
    apb(1'b1, REG_IRQ_MASK, 32'h7, 33'h0);
    apb(1'b1, REG_CTRL, 32'h1, 33'h0);
    frames(3, LABEL_EXPECTED);
    apb(1'b0, REG_STATUS, 32'h0, 33'h30);
    frames(1, LABEL_EXPECTED);
    apb(1'b0, REG_STATUS, 32'h0, 33'h34);
    cmp_lvl(downstream_signal_fail, 1'b0);
    // Only the sinks switched on in word 0 may leave fail low
    cmp_val({1'b0, tu_fail[31:0]}, {1'b0, ~td});
    cmp_lvl(&tu_fail[N_TU-1:32], 1'b1);
    cmp_lvl(irq, 1'b1);
    apb(1'b0, REG_IRQ_STAT, 32'h0, 33'h4);
    apb(1'b1, REG_IRQ_STAT, 32'h4, 33'h0);
    cyc(3);
    cmp_lvl(irq, 1'b0);
    m0 = mfs_n;
    frames(5, LABEL_EXPECTED);
    cmp_val(33'(mfs_n - m0), 33'h2);
    // A single wrong code, then the loss window with its irq masked
    tma_path_model_i.frame(LABEL_EXPECTED, mf_code + 2'h2);
    mf_code = mf_code + 2'h3;
    cyc(8);
    apb(1'b0, REG_STATUS, 32'h0, 33'h30);
    apb(1'b1, REG_IRQ_MASK, 32'h1, 33'h0);
    cyc(LOM - 100);
    cmp_lvl(multiframe_loss_cause, 1'b0);
    cyc(200);
    cmp_lvl(multiframe_loss_cause, 1'b1);
    cmp_lvl(downstream_signal_fail, 1'b1);
    cmp_lvl(irq, 1'b0);
    apb(1'b0, REG_IRQ_STAT, 32'h0, 33'h2);
    // Trail fail hides the loss cause while the defect stays
    incoming_trail_fail <= 1'b1;
    cyc(6);
    cmp_lvl(multiframe_loss_cause, 1'b0);
    incoming_trail_fail <= 1'b0;
    cyc(6);
    cmp_lvl(multiframe_loss_cause, 1'b1);
    frames(4, LABEL_EXPECTED);
    cmp_lvl(multiframe_loss_cause, 1'b0);
    frames(4, 3'h5);
    cmp_lvl(label_mismatch_cause, 1'b0);
    frames(1, 3'h5);
    cmp_lvl(label_mismatch_cause, 1'b1);
    cmp_lvl(downstream_signal_fail, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0, 33'h55);
    incoming_trail_fail <= 1'b1;
    cyc(6);
    cmp_lvl(label_mismatch_cause, 1'b0);
    incoming_trail_fail <= 1'b0;
    frames(5, LABEL_EXPECTED);
    cmp_lvl(label_mismatch_cause, 1'b0);
    cmp_lvl(downstream_signal_fail, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0, 33'h0);
    cyc(4);
    cmp_lvl(downstream_signal_fail, 1'b1);
    cmp_lvl(&tu_fail, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0, 33'h0);
    final_report();
  end
endmodule // tb_top
